// [epl_consts.svh]
`ifndef EPL_CONSTS_SVH
`define EPL_CONSTS_SVH
// register byte addresses
`define EPL_ADDR_CTRL 4'h0
`define EPL_ADDR_STATUS 4'h4
`define EPL_ADDR_DROPS 4'h8
// control field positions
`define EPL_CTRL_ACTIVE 0
`define EPL_CTRL_SPD_LO 1
`define EPL_CTRL_SPD_HI 3
`define EPL_CTRL_FC 4
`define EPL_CTRL_JUMBO 5
`define EPL_CTRL_PRIO_LO 6
`define EPL_CTRL_PRIO_HI 8
`define EPL_CTRL_W 10
`define EPL_CTRL_RESET 10'h001
// peer / local ability bits
`define EPL_AB_10H 0
`define EPL_AB_10F 1
`define EPL_AB_100H 2
`define EPL_AB_100F 3
`define EPL_AB_1000F 4
`define EPL_AB_COPPER 5'h1F
`define EPL_AB_FIBRE 5'h10
// frame limits
`define EPL_MAX_PAYLOAD 16'h05DC
// negotiation wait: time in ns, cycles derived from 10 ns clock
`define EPL_ANEG_WAIT_NS 10000
`define EPL_CLK_NS 10
`define EPL_ANEG_CYC ((`EPL_ANEG_WAIT_NS + `EPL_CLK_NS - 1) / `EPL_CLK_NS)
`define EPL_FIFO_DEPTH 4
`define EPL_FIFO_W 19
`endif

// [epl_peer_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// link partner: line state and frame source
// ----------------------------------------
module epl_peer_model (
   input wire logic core_clk,
   input wire logic rxReady,
   output logic signalDetect,
   output logic [1:0] sensedSpeed,
   output logic peerAbilValid,
   output logic [4:0] peerAbility,
   output logic rxValid,
   output logic [15:0] rxPayloadLen,
   output logic rxHasTag,
   output logic [2:0] rxTagPrio
);
   initial begin
      {signalDetect, sensedSpeed, peerAbilValid, peerAbility, rxValid} = '0;
      {rxPayloadLen, rxHasTag, rxTagPrio} = '1;
   end
   // bounce the line; a silent peer leaves stale-looking ability bits
   task link(input logic talk, input logic [1:0] spd, input logic [4:0] ab);
      @(posedge core_clk) signalDetect <= 1'b0;
      repeat (4) @(posedge core_clk);
      signalDetect <= 1'b1;
      sensedSpeed <= spd;
      peerAbilValid <= talk;
      peerAbility <= talk ? ab : ~ab;
   endtask
   // sender holds the frame until taken, stalling while not ready
   task send(input logic [15:0] len, input logic tag, input logic [2:0] pr);
      @(posedge core_clk) rxValid <= 1'b1;
      {rxPayloadLen, rxHasTag, rxTagPrio} <= {len, tag, pr};
      @(posedge core_clk);
      while (rxReady !== 1'b1) @(posedge core_clk);
      rxValid <= 1'b0;
      {rxPayloadLen, rxHasTag, rxTagPrio} <= ~{len, tag, pr};
   endtask
endmodule

// [epl_pkg.sv]
package epl_pkg;
   // speed/duplex choices held in the control register
   typedef enum logic [2:0] {
      SD_AUTO = 3'h0,
      SD_10H = 3'h1,
      SD_10F = 3'h2,
      SD_100H = 3'h3,
      SD_100F = 3'h4,
      SD_1000F = 3'h5
   } epl_sd_t;
   // resolved line rate
   typedef enum logic [1:0] {
      SPD_10 = 2'h0,
      SPD_100 = 2'h1,
      SPD_1000 = 2'h2
   } epl_speed_t;
endpackage

// [epl_port.sv]
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "epl_consts.svh"
// Notes on behaviour
// - A copper port offers automatic, 10 half, 10 full, 100 half and 100 full speed/duplex settings.
// - Gigabit runs full duplex only and is offered on both copper and fibre ports; a silent peer sensed at gigabit comes up half duplex.
// - In automatic mode the port negotiates and picks the best combination both ends support.
// - A peer that never negotiates leaves the port on the sensed line speed in half duplex.
// - With negotiation off the configured speed and duplex are used unchanged; the peer must match.
// - Flow control in full duplex uses the standard pause mechanism.
// - In full duplex a filling receive buffer sends a pause so the sender stops for a while.
// - Flow control in half duplex forces a collision so the sender backs off and resends.
// - Received frames without a priority tag get the port's default priority.
// - A frame whose payload exceeds 1500 bytes counts as jumbo.
// - Jumbo frames pass when the jumbo setting is on and are discarded when it is off.
// - No frame passes while the port is inactive, and the port starts active.

// ----------------------------------------
// descriptor fifo
// ----------------------------------------
module epl_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 4
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   wire push = inValid && inReady;
   wire pop = outValid && outReady;

   // honest full and empty straight from the count
   assign inReady = (count < (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];

   // pointers wrap naturally since depth is a power of two
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) wrPtr <= wrPtr + 1'b1;
         if (pop) rdPtr <= rdPtr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // storage carries no reset
   always_ff @(posedge core_clk) begin
      if (push) mem[wrPtr] <= inData;
   end
endmodule

// ----------------------------------------
// port link and admission
// ----------------------------------------
module epl_port (
   input wire logic core_clk,
   input wire logic rstn,
   // axi4-lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // line side
   input wire logic portIsFibre,
   input wire logic signalDetect,
   input wire logic [1:0] sensedSpeed,
   input wire logic peerAbilValid,
   input wire logic [4:0] peerAbility,
   output logic pauseReq,
   output logic jamReq,
   // received frame descriptors
   input wire logic rxValid,
   output logic rxReady,
   input wire logic [15:0] rxPayloadLen,
   input wire logic rxHasTag,
   input wire logic [2:0] rxTagPrio,
   // fabric side
   output logic fabValid,
   input wire logic fabReady,
   output logic [15:0] fabPayloadLen,
   output logic [2:0] fabPrio
);
   typedef enum {LK_DOWN, LK_NEG, LK_UP} epl_link_t;

   logic [`EPL_CTRL_W-1:0] ctrl;
   logic [31:0] drops;
   epl_link_t linkState;
   epl_pkg::epl_speed_t speed;
   logic fullDuplex;
   logic viaParallel;
   logic [13:0] anegTimer;
   logic cfgChanged;
   logic awHeld;
   logic wHeld;
   logic [3:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;

   // ---------------- register decode ----------------
   wire doWrite = awHeld && wHeld && !s_axi_bvalid;
   wire wrCtrl = doWrite && (awAddr == `EPL_ADDR_CTRL);
   wire wrHit = (awAddr == `EPL_ADDR_CTRL) || (awAddr == `EPL_ADDR_STATUS) || (awAddr == `EPL_ADDR_DROPS);
   wire rdHit = (s_axi_araddr == `EPL_ADDR_CTRL) || (s_axi_araddr == `EPL_ADDR_STATUS)
      || (s_axi_araddr == `EPL_ADDR_DROPS);
   wire [2:0] newSd = wData[`EPL_CTRL_SPD_HI:`EPL_CTRL_SPD_LO];
   // fibre only takes auto or gigabit full; gigabit has no half choice at all
   wire sdLegal = portIsFibre ? (newSd == epl_pkg::SD_AUTO || newSd == epl_pkg::SD_1000F)
      : (newSd <= epl_pkg::SD_1000F);
   wire [7:0] ctrlLo = {wData[7:4], sdLegal ? newSd : ctrl[`EPL_CTRL_SPD_HI:`EPL_CTRL_SPD_LO], wData[0]};
   wire [`EPL_CTRL_W-1:0] next_ctrl = {wStrb[1] ? wData[9:8] : ctrl[9:8], wStrb[0] ? ctrlLo : ctrl[7:0]};
   wire [31:0] statusWord = {26'h0, viaParallel, linkState == LK_NEG, fullDuplex, speed, linkState == LK_UP};
   wire [31:0] rdWord = (s_axi_araddr == `EPL_ADDR_CTRL) ? {22'h0, ctrl}
      : (s_axi_araddr == `EPL_ADDR_STATUS) ? statusWord : drops;

   // write channel: address and data taken in either order
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 4'h0;
         wData <= 32'h0;
         wStrb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !wHeld && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= {s_axi_awaddr[3:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? 2'h0 : 2'h2; // unmapped answers slverr
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
         end
      end
   end

   // control register; starts active with auto negotiation
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= `EPL_CTRL_RESET;
         cfgChanged <= 1'b0;
      end else begin
         cfgChanged <= wrCtrl && (next_ctrl[`EPL_CTRL_SPD_HI:`EPL_CTRL_SPD_LO]
            != ctrl[`EPL_CTRL_SPD_HI:`EPL_CTRL_SPD_LO]);
         if (wrCtrl) ctrl <= next_ctrl;
      end
   end

   // read channel: one cycle after the address is taken
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdHit ? rdWord : 32'h0;
            s_axi_rresp <= rdHit ? 2'h0 : 2'h2;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ---------------- link resolution ----------------
   wire [2:0] sdSel = ctrl[`EPL_CTRL_SPD_HI:`EPL_CTRL_SPD_LO];
   wire [4:0] localAbil = portIsFibre ? `EPL_AB_FIBRE : `EPL_AB_COPPER;
   wire [4:0] common = peerAbility & localAbil;
   wire anegExpired = (anegTimer == 14'(`EPL_ANEG_CYC - 1));
   // highest common ability wins
   wire [1:0] negSpeed = common[`EPL_AB_1000F] ? epl_pkg::SPD_1000
      : (common[`EPL_AB_100F] || common[`EPL_AB_100H]) ? epl_pkg::SPD_100 : epl_pkg::SPD_10;
   wire negFull = common[`EPL_AB_1000F] || (common[`EPL_AB_100F]) || (!common[`EPL_AB_100H] && common[`EPL_AB_10F]);
   wire [1:0] forcedSpeed = (sdSel == epl_pkg::SD_1000F) ? epl_pkg::SPD_1000
      : (sdSel >= epl_pkg::SD_100H) ? epl_pkg::SPD_100 : epl_pkg::SPD_10;
   wire forcedFull = (sdSel == epl_pkg::SD_10F) || (sdSel == epl_pkg::SD_100F) || (sdSel == epl_pkg::SD_1000F);

   // link state; a speed/duplex change restarts bring-up so the new setting is used
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         linkState <= LK_DOWN;
         speed <= epl_pkg::SPD_10;
         fullDuplex <= 1'b0;
         viaParallel <= 1'b0;
         anegTimer <= 14'h0;
      end else begin
         case (linkState)
            LK_DOWN: begin
               anegTimer <= 14'h0;
               if (signalDetect && sdSel == epl_pkg::SD_AUTO) begin
                  linkState <= LK_NEG;
               end else if (signalDetect) begin
                  linkState <= LK_UP;
                  speed <= epl_pkg::epl_speed_t'(forcedSpeed);
                  fullDuplex <= forcedFull;
                  viaParallel <= 1'b0;
               end
            end
            LK_NEG: begin
               anegTimer <= anegTimer + 14'h1;
               if (!signalDetect || cfgChanged) begin
                  linkState <= LK_DOWN;
               end else if (peerAbilValid && common != 5'h0) begin
                  linkState <= LK_UP;
                  speed <= epl_pkg::epl_speed_t'(negSpeed);
                  fullDuplex <= negFull;
                  viaParallel <= 1'b0;
               end else if (anegExpired) begin
                  // silent peer: sensed rate, half duplex
                  linkState <= LK_UP;
                  speed <= epl_pkg::epl_speed_t'(sensedSpeed);
                  fullDuplex <= 1'b0;
                  viaParallel <= 1'b1;
               end
            end
            LK_UP: begin
               if (!signalDetect || cfgChanged) linkState <= LK_DOWN;
            end
            default: linkState <= LK_DOWN;
         endcase
      end
   end

   // ---------------- frame admission ----------------
   logic stageValid;
   logic [`EPL_FIFO_W-1:0] stageData;
   wire fifoReady;
   wire [`EPL_FIFO_W-1:0] fifoOut;
   wire fifoValid;
   wire headFree = !fabValid || fabReady;
   wire headLoad = headFree && fifoValid;
   wire isJumbo = rxPayloadLen > `EPL_MAX_PAYLOAD;
   wire admit = ctrl[`EPL_CTRL_ACTIVE] && (linkState == LK_UP)
      && (!isJumbo || ctrl[`EPL_CTRL_JUMBO]);
   wire [2:0] framePrio = rxHasTag ? rxTagPrio : ctrl[`EPL_CTRL_PRIO_HI:`EPL_CTRL_PRIO_LO];
   wire rxTake = rxValid && rxReady;
   wire stageFree = !stageValid || fifoReady;
   // congestion: staging slot held while the fifo refuses more
   wire congested = stageValid && !fifoReady;

   // one staging slot keeps rxReady a flop; ready rests a cycle after each admitted take,
   // since a flopped ready cannot see the fifo fill in time and would let the slot be overwritten
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         stageValid <= 1'b0;
         stageData <= '0;
         rxReady <= 1'b0;
         drops <= 32'h0;
      end else begin
         if (rxTake && admit) begin
            stageValid <= 1'b1;
            stageData <= {framePrio, rxPayloadLen};
         end else if (fifoReady) begin
            stageValid <= 1'b0;
         end
         rxReady <= stageFree && !(rxTake && admit);
         if (rxTake && !admit) drops <= drops + 32'h1;
      end
   end

   // flow control towards the sender, chosen by duplex
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pauseReq <= 1'b0;
         jamReq <= 1'b0;
      end else begin
         pauseReq <= ctrl[`EPL_CTRL_FC] && (linkState == LK_UP) && fullDuplex && congested;
         jamReq <= ctrl[`EPL_CTRL_FC] && (linkState == LK_UP) && !fullDuplex && congested;
      end
   end

   epl_fifo #(
      .WIDTH(`EPL_FIFO_W),
      .DEPTH(`EPL_FIFO_DEPTH)
   ) u_epl_fifo (
      .core_clk(core_clk),
      .rstn(rstn),
      .inValid(stageValid),
      .inReady(fifoReady),
      .inData(stageData),
      .outValid(fifoValid),
      .outReady(headFree),
      .outData(fifoOut)
   );

   // fabric outputs held in flops; the head slot refills whenever it is empty or taken
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fabValid <= 1'b0;
         fabPayloadLen <= 16'h0;
         fabPrio <= 3'h0;
      end else begin
         if (headFree) fabValid <= fifoValid;
         if (headLoad) {fabPrio, fabPayloadLen} <= fifoOut;
      end
   end
endmodule

// [epl_port_properties.sv]
`timescale 1ns/10ps
// ----------------------------------------
// flow control and fabric checks
// ----------------------------------------
module epl_port_properties (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic rxReady,
   input wire logic rxValid,
   input wire logic pauseReq,
   input wire logic jamReq,
   input wire logic fabValid,
   input wire logic fabReady,
   input wire logic [15:0] fabPayloadLen,
   input wire logic [2:0] fabPrio
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // one duplex mode at a time, so never both mechanisms
   AST_PAUSE_JAM_EXCL: assert property (
      !(pauseReq && jamReq)) else $error("pause and jam raised together");
   AST_PAUSE_BLOCK: assert property (
      pauseReq |-> !rxReady) else $error("pause while still accepting");
   AST_JAM_BLOCK: assert property (
      jamReq |-> !rxReady) else $error("jam while still accepting");
   // congestion means the fifo is full, so its head is valid
   AST_PAUSE_CAUSE: assert property (
      $rose(pauseReq) |-> fabValid && !$past(fabReady)) else $error("pause without congestion");
   AST_JAM_CAUSE: assert property (
      $rose(jamReq) |-> fabValid && !$past(fabReady)) else $error("jam without congestion");
   AST_PAUSE_HOLD: assert property (
      pauseReq && !fabReady |=> pauseReq) else $error("pause dropped while congested");
   AST_FAB_HOLD: assert property (
      fabValid && !fabReady |=> fabValid && $stable(fabPayloadLen) && $stable(fabPrio))
      else $error("fabric head changed while stalled");
   // ready rests only after an admitted take, so a stalled sender never loses a frame
   AST_READY_FALL: assert property (
      $fell(rxReady) |-> $past(rxValid && rxReady)) else $error("ready fell without a frame taken");
endmodule

// [epl_port_test.sv]
`timescale 1ns/10ps
// ----------------------------------------
// port link and admission bench
// ----------------------------------------
module epl_port_test;
   logic core_clk = 0, rstn = 0, portIsFibre = 0, fabReady = 1;
   logic [3:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdData;
   logic awready, wready, bvalid, arready, rvalid, pauseReq, jamReq, rxReady, fabValid;
   logic [1:0] bresp, rresp, rdResp, sensedSpeed;
   logic [31:0] rdata;
   logic signalDetect, peerAbilValid, rxValid, rxHasTag;
   logic [4:0] peerAbility;
   logic [15:0] rxPayloadLen, fabPayloadLen;
   logic [2:0] rxTagPrio, fabPrio;
   logic [18:0] got[$];
   int failures = 0, n_compared = 0;
   always #5 core_clk = ~core_clk;
   epl_port u_epl_port (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .portIsFibre(portIsFibre),
      .signalDetect(signalDetect), .sensedSpeed(sensedSpeed), .peerAbilValid(peerAbilValid),
      .peerAbility(peerAbility), .pauseReq(pauseReq), .jamReq(jamReq), .rxValid(rxValid), .rxReady(rxReady),
      .rxPayloadLen(rxPayloadLen), .rxHasTag(rxHasTag), .rxTagPrio(rxTagPrio), .fabValid(fabValid),
      .fabReady(fabReady), .fabPayloadLen(fabPayloadLen), .fabPrio(fabPrio));
   epl_peer_model u_epl_peer_model (.core_clk(core_clk), .rxReady(rxReady), .signalDetect(signalDetect),
      .sensedSpeed(sensedSpeed), .peerAbilValid(peerAbilValid), .peerAbility(peerAbility), .rxValid(rxValid),
      .rxPayloadLen(rxPayloadLen), .rxHasTag(rxHasTag), .rxTagPrio(rxTagPrio));
   // fabric sink records every delivered descriptor
   always @(posedge core_clk) if (fabValid === 1'b1 && fabReady === 1'b1) got.push_back({fabPayloadLen, fabPrio});
   task conclude;
      $display("mismatches %0d, comparisons %0d", failures, n_compared);
      if (failures == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   // write: release each channel when taken, response last
   task axiW(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk) {awaddr, awvalid, wdata, wvalid, bready} <= {a, 1'b1, d, 2'b11};
      do begin
         @(posedge core_clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (bvalid !== 1'b1);
      bready <= 0;
      chk("bresp", 32'h0, bresp);
   endtask
   task rdChk(input string n, input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk) {araddr, arvalid, rready} <= {a, 2'b11};
      do begin
         @(posedge core_clk);
         if (arready) arvalid <= 0;
      end while (rvalid !== 1'b1);
      rdData = rdata;
      rdResp = rresp;
      rready <= 1'b0;
      chk(n, e, rdData);
   endtask
   task tRegs; // reset value, unmapped place, fibre speed limits
      rdChk("ctrl", 4'h0, 32'h001);
      rdChk("unmapped", 4'hC, 32'h0);
      chk("rresp", 2, rdResp);
      portIsFibre <= 1;
      axiW(4'h0, 32'h003);
      rdChk("ctrl", 4'h0, 32'h001);
      axiW(4'h0, 32'h00B);
      rdChk("ctrl", 4'h0, 32'h00B);
      axiW(4'h0, 32'h001);
      portIsFibre <= 0;
   endtask
   task automatic tNeg; // best common mode, then a silent peer
      logic [4:0] ab[3] = '{5'h0C, 5'h1F, 5'h03};
      logic [31:0] ex[3] = '{32'h0B, 32'h0D, 32'h09};
      for (int i = 0; i < 3; i++) begin
         u_epl_peer_model.link(1, 0, ab[i]);
         repeat (30) @(posedge core_clk);
         rdChk("status", 4'h4, ex[i]);
      end
      u_epl_peer_model.link(0, 2'h1, 0);
      repeat (1100) @(posedge core_clk);
      rdChk("status", 4'h4, 32'h23);
   endtask
   task automatic tForced; // every fixed speed and duplex code
      logic [31:0] ex[5] = '{32'h01, 32'h09, 32'h03, 32'h0B, 32'h0D};
      for (int sd = 1; sd < 6; sd++) begin
         axiW(4'h0, 32'h1 | (sd << 1));
         u_epl_peer_model.link(0, 0, 0);
         repeat (10) @(posedge core_clk);
         rdChk("status", 4'h4, ex[sd-1]);
      end
   endtask
   task automatic tFrames; // priority fill, jumbo boundary, inactive port
      logic [18:0] ex[4] = '{{16'd100, 3'd5}, {16'd60, 3'd3}, {16'd1500, 3'd5}, {16'd1501, 3'd7}};
      axiW(4'h0, 32'h149);
      u_epl_peer_model.link(0, 1, 0);
      repeat (10) @(posedge core_clk);
      got.delete();
      u_epl_peer_model.send(100, 0, 6);
      u_epl_peer_model.send(60, 1, 3);
      u_epl_peer_model.send(1500, 0, 0);
      u_epl_peer_model.send(1501, 0, 0);
      axiW(4'h0, 32'h169);
      u_epl_peer_model.send(1501, 1, 7);
      axiW(4'h0, 32'h168);
      u_epl_peer_model.send(64, 0, 0);
      repeat (10) @(posedge core_clk);
      chk("count", 4, got.size());
      for (int i = 0; i < 4 && i < got.size(); i++) chk("frame", ex[i], got[i]);
      rdChk("drops", 4'h8, 32'h2);
   endtask
   task automatic tFlow; // full duplex pauses, half duplex jams
      logic [31:0] ct[2] = '{32'h179, 32'h177};
      for (int m = 0; m < 2; m++) begin
         axiW(4'h0, ct[m]);
         u_epl_peer_model.link(0, 1, 0);
         repeat (10) @(posedge core_clk) fabReady <= 0;
         repeat (6) u_epl_peer_model.send(200, 0, 0); // head slot and fifo fill, the sixth blocks the stage
         repeat (3) @(posedge core_clk);
         chk("pause", m == 0, pauseReq);
         chk("jam", m == 1, jamReq);
         fabReady <= 1;
         repeat (10) @(posedge core_clk);
         chk("relief", 0, pauseReq | jamReq);
      end
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      rstn <= 1;
      tRegs();
      tNeg();
      tForced();
      tFrames();
      tFlow();
      conclude();
   end
   // watchdog well beyond the roughly 1500 cycles of traffic
   initial begin
      #200000;
      failures++;
      conclude();
   end
endmodule
bind epl_port epl_port_properties u_epl_port_properties (.core_clk(core_clk), .rstn(rstn), .rxReady(rxReady),
   .rxValid(rxValid), .pauseReq(pauseReq), .jamReq(jamReq), .fabValid(fabValid), .fabReady(fabReady),
   .fabPayloadLen(fabPayloadLen), .fabPrio(fabPrio));
